// file: adtc_pkg.sv
// Shared constants for the A/D timing, trigger and channel control block.
// Assumes a 20-bit byte address space and one peripheral clock.
package adtc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam logic [19:0] OFS_RESULT_WORD = 20'hFFF1E;
   localparam logic [19:0] OFS_RESULT_BYTE = 20'hFFF1F;
   localparam logic [19:0] OFS_MODE = 20'hFFF30;
   localparam logic [19:0] OFS_CHANNEL = 20'hFFF31;
   localparam logic [19:0] OFS_TRIGGER = 20'hFFF42;
   localparam logic [19:0] OFS_STATUS = 20'hFFF43;

   // ----------------------------------------------------------------
   // Field positions, masks and reset values
   // ----------------------------------------------------------------
   localparam int MODE_RUN_BIT = 7;
   localparam int MODE_SCAN_BIT = 6;
   localparam int MODE_DIV_LSB = 3;
   localparam int MODE_SPEED_LSB = 1;
   localparam int MODE_CMP_EN_BIT = 0;
   localparam int TRIG_SRC_BIT = 7;
   localparam int TRIG_SEL_BIT = 0;
   localparam int CHAN_AMP_BIT = 6;
   localparam logic [7:0] CHAN_WRITE_MASK = 8'h4F;
   localparam logic [7:0] TRIG_WRITE_MASK = 8'h81;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CHAN_RST = 8'h00;
   localparam logic [7:0] TRIG_RST = 8'h00;
   localparam logic [15:0] RESULT_WORD_RST = 16'h0000;
   localparam logic [7:0] RESULT_BYTE_RST = 8'h00;
   localparam logic [5:0] RESULT_PAD = 6'h00;

   // ----------------------------------------------------------------
   // Speed modes, divider ratios, channel codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SPEED_STD = 2'h0;
   localparam logic [1:0] SPEED_BOOST = 2'h1;
   localparam logic [1:0] SPEED_HS1 = 2'h2;
   localparam logic [1:0] SPEED_HS2 = 2'h3;
   localparam logic [4:0] DIV_RATIO [0:7] = '{5'h14, 5'h0A, 5'h08, 5'h06,
                                              5'h04, 5'h03, 5'h02, 5'h01};
   localparam int SAR_BITS = 10;
   localparam logic [9:0] SAR_MSB_TRIAL = 10'h200;
   localparam logic [3:0] SAMPLE_TICKS = 4'h2;
   localparam logic [1:0] LAST_SLOT = 2'h3;
   localparam logic [3:0] SCAN_MAX_BASE_PIN = 4'h6;
   localparam logic [3:0] SCAN_MAX_BASE_AMP = 4'h7;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_CONVERT} adtc_state_e;

endpackage : adtc_pkg

// file: adtc_clk_div.sv
// Conversion clock divider: one-cycle tick every N peripheral clocks.
// Assumes restart is a same-clock pulse from the controller.
module adtc_clk_div
   import adtc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control
   input wire logic restart,
   input wire logic [2:0] divCode,
   // Tick out
   output logic tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } adtc_div_s;

   adtc_div_s divReg;
   adtc_div_s divNext;
   logic [4:0] lastCount;

   assign lastCount = DIV_RATIO[divCode] - 5'h01;

   always_comb begin
      divNext = divReg;
      if (restart) begin
         divNext.cnt = 5'h00;
         divNext.tick = 1'b0;
      end else if (divReg.cnt >= lastCount) begin
         divNext.cnt = 5'h00;
         divNext.tick = 1'b1;
      end else begin
         divNext.cnt = divReg.cnt + 5'h01;
         divNext.tick = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         divReg <= '0;
      end else begin
         divReg <= divNext;
      end
   end

   assign tick = divReg.tick;
endmodule : adtc_clk_div

// file: adtc_sar.sv
// Successive approximation sequencer: sample phase, then ten trials.
// Assumes compareHigh answers the trial value within one conversion tick.
module adtc_sar
   import adtc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control
   input wire logic start,
   input wire logic abort,
   input wire logic tick,
   input wire logic compareHigh,
   // Status and result
   output logic sampling,
   output logic busy,
   output logic done,
   output logic [9:0] trial,
   output logic [9:0] result
);
   typedef struct packed {
      logic busy;
      logic sampling;
      logic done;
      logic [3:0] cnt;
      logic [3:0] bitIdx;
      logic [9:0] sar;
      logic [9:0] result;
   } adtc_sar_s;

   adtc_sar_s sarReg;
   adtc_sar_s sarNext;

   always_comb begin
      sarNext = sarReg;
      sarNext.done = 1'b0;
      if (abort) begin
         sarNext.busy = 1'b0;
         sarNext.sampling = 1'b0;
      end else if (start) begin
         sarNext.busy = 1'b1;
         sarNext.sampling = 1'b1;
         sarNext.cnt = 4'h0;
      end else if (sarReg.busy && tick) begin
         if (sarReg.sampling) begin
            sarNext.cnt = sarReg.cnt + 4'h1;
            if (sarReg.cnt == SAMPLE_TICKS - 4'h1) begin
               sarNext.sampling = 1'b0;
               sarNext.sar = SAR_MSB_TRIAL;
               sarNext.bitIdx = 4'(SAR_BITS - 1);
            end
         end else begin
            sarNext.sar[sarReg.bitIdx] = compareHigh;
            if (sarReg.bitIdx == 4'h0) begin
               sarNext.busy = 1'b0;
               sarNext.done = 1'b1;
               sarNext.result = {sarReg.sar[9:1], compareHigh};
            end else begin
               sarNext.sar[sarReg.bitIdx - 4'h1] = 1'b1;
               sarNext.bitIdx = sarReg.bitIdx - 4'h1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sarReg <= '0;
      end else begin
         sarReg <= sarNext;
      end
   end

   assign sampling = sarReg.sampling;
   assign busy = sarReg.busy;
   assign done = sarReg.done;
   assign trial = sarReg.sar;
   assign result = sarReg.result;
endmodule : adtc_sar

// file: adtc_ctrl.sv
// A/D converter control: mode, trigger, channel select and result registers.
// Assumes a same-clock analog front end and a one-cycle register port.
//
// Function
// - Divider code selects fclk divide ratio
// - Trigger bit 7 picks software or timer
// - Trigger bit 0 picks timer trigger line
// - Trigger register resets zero, bits 6-1 zero
// - Result word left-justified, low six bits zero
// - High byte upper eight, low byte two
// - Result word 16-bit read, reset zero
// - Result byte holds top eight bits
// - Results may be stale after config writes
// - Select mode picks one input or amplifier
// - Scan mode converts four consecutive slots
// - Channel register byte writable, resets zero
// - Mode bit picks select or scan
// - Run bit starts; repeats until cleared
// - Channel write during conversion restarts it
// - Completion loads both results, flags end
//
// The address-and-strobe port was decided locally.
module adtc_ctrl
   import adtc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [adtc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [adtc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [adtc_pkg::DATA_W-1:0] regRdData,
   // Timer triggers, same clock, one-cycle pulses
   input wire logic timerTrig0,
   input wire logic timerTrig1,
   // Reference range pin, asynchronous
   input wire logic refRangeLow,
   // Analog front end
   input wire logic compareHigh,
   output logic comparatorEnable,
   output logic sampleHold,
   output logic [9:0] trialValue,
   output logic [3:0] channelCode,
   output logic amplifierSelect,
   output logic [1:0] speedMode,
   // Events
   output logic conversionEnd
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] chan;
      logic [7:0] trig;
      logic [15:0] resWord;
      logic [7:0] resByte;
      logic [15:0] rdData;
      adtc_state_e state;
      logic [1:0] slot;
      logic rangeSync1;
      logic rangeSync2;
      logic settingErr;
      logic convEnd;
      logic [3:0] muxCode;
      logic muxAmp;
   } adtc_ctrl_s;

   adtc_ctrl_s ctlReg;
   adtc_ctrl_s ctlNext;

   logic wrMode;
   logic wrChan;
   logic wrTrig;
   logic runBit;
   logic scanMode;
   logic hwTrigMode;
   logic selTrig;
   logic prohibited;
   logic sarStart;
   logic sarAbort;
   logic divRestart;
   logic divTick;
   logic sarSampling;
   logic sarBusy;
   logic sarDone;
   logic [9:0] sarTrial;
   logic [9:0] sarResult;
   logic [4:0] slotSel;
   logic [15:0] readMux;

   // ----------------------------------------------------------------
   // Channel decode
   // ----------------------------------------------------------------
   // Returns {amplifier, pin code} for a channel register value and slot
   function automatic logic [4:0] chanForSlot(input logic [7:0] chan,
                                              input logic scan,
                                              input logic [1:0] slot);
      logic amp;
      logic [3:0] code;
      logic [4:0] sel;
      amp = chan[CHAN_AMP_BIT];
      code = chan[3:0];
      sel = {1'b0, code};
      if (!scan) begin
         sel = amp ? {1'b1, 4'h0} : {1'b0, code};
      end else if (!amp) begin
         sel = (code <= SCAN_MAX_BASE_PIN) ? {1'b0, code + {2'h0, slot}}
                                           : {1'b0, 2'h0, slot};
      end else if (code <= SCAN_MAX_BASE_AMP) begin
         sel = (slot == 2'h0) ? {1'b1, 4'h0}
                              : {1'b0, code + {2'h0, slot} - 4'h1};
      end else begin
         sel = {1'b0, 2'h0, slot};
      end
      return sel;
   endfunction : chanForSlot

   // ----------------------------------------------------------------
   // Register decode and control bits
   // ----------------------------------------------------------------
   assign wrMode = regWrite && (regAddr == OFS_MODE);
   assign wrChan = regWrite && (regAddr == OFS_CHANNEL);
   assign wrTrig = regWrite && (regAddr == OFS_TRIGGER);
   assign runBit = ctlReg.mode[MODE_RUN_BIT];
   assign scanMode = ctlReg.mode[MODE_SCAN_BIT];
   assign hwTrigMode = ctlReg.trig[TRIG_SRC_BIT];
   assign selTrig = ctlReg.trig[TRIG_SEL_BIT] ? timerTrig1 : timerTrig0;
   // barred speed modes in low range, or comparator disabled
   assign prohibited = !ctlReg.mode[MODE_CMP_EN_BIT] ||
                       (ctlReg.rangeSync2 &&
                        (speedMode == SPEED_BOOST || speedMode == SPEED_HS1));
   assign slotSel = chanForSlot(ctlReg.chan, scanMode, ctlReg.slot);

   always_comb begin
      readMux = 16'h0000;
      case (regAddr)
         OFS_RESULT_WORD: readMux = ctlReg.resWord;
         OFS_RESULT_BYTE: readMux = {8'h00, ctlReg.resByte};
         OFS_MODE: readMux = {8'h00, ctlReg.mode};
         OFS_CHANNEL: readMux = {8'h00, ctlReg.chan};
         OFS_TRIGGER: readMux = {8'h00, ctlReg.trig};
         OFS_STATUS: readMux = {12'h000, ctlReg.settingErr, sarBusy,
                                ctlReg.state == ST_WAIT_TRIG,
                                ctlReg.state == ST_CONVERT};
         default: readMux = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      ctlNext = ctlReg;
      sarStart = 1'b0;
      sarAbort = 1'b0;
      divRestart = 1'b0;
      ctlNext.convEnd = 1'b0;
      ctlNext.rangeSync1 = refRangeLow;
      ctlNext.rangeSync2 = ctlReg.rangeSync1;
      ctlNext.rdData = regRead ? readMux : 16'h0000;
      ctlNext.muxCode = slotSel[3:0];
      ctlNext.muxAmp = slotSel[4];

      if (wrMode) begin
         ctlNext.mode = regWrData[7:0];
      end
      if (wrChan) begin
         ctlNext.chan = regWrData[7:0] & CHAN_WRITE_MASK;
      end
      if (wrTrig) begin
         ctlNext.trig = regWrData[7:0] & TRIG_WRITE_MASK;
      end

      case (ctlReg.state)
         ST_IDLE: begin
            ctlNext.slot = 2'h0;
            if (runBit && !prohibited) begin
               divRestart = 1'b1;
               if (hwTrigMode) begin
                  ctlNext.state = ST_WAIT_TRIG;
               end else begin
                  sarStart = 1'b1;
                  ctlNext.state = ST_CONVERT;
               end
            end
         end
         ST_WAIT_TRIG: begin
            if (selTrig) begin
               sarStart = 1'b1;
               divRestart = 1'b1;
               ctlNext.slot = 2'h0;
               ctlNext.state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (sarDone) begin
               if (scanMode && ctlReg.slot != LAST_SLOT) begin
                  ctlNext.slot = ctlReg.slot + 2'h1;
                  sarStart = 1'b1;
               end else begin
                  ctlNext.convEnd = 1'b1;
                  ctlNext.slot = 2'h0;
                  if (hwTrigMode) begin
                     ctlNext.state = ST_WAIT_TRIG;
                  end else begin
                     sarStart = 1'b1;
                  end
               end
            end
         end
         default: begin
            ctlNext.state = ST_IDLE;
         end
      endcase

      if (sarDone && ctlReg.state == ST_CONVERT) begin
         ctlNext.resWord = {sarResult, RESULT_PAD};
         ctlNext.resByte = sarResult[9:2];
      end

      if (wrChan && ctlReg.state != ST_IDLE) begin
         sarAbort = 1'b1;
         sarStart = 1'b0;
         ctlNext.convEnd = 1'b0;
         ctlNext.slot = 2'h0;
         ctlNext.state = ST_IDLE;
      end

      if (!runBit) begin
         sarAbort = ctlReg.state != ST_IDLE;
         sarStart = 1'b0;
         ctlNext.state = ST_IDLE;
         ctlNext.settingErr = 1'b0;
      end else if (ctlReg.state == ST_IDLE && prohibited) begin
         ctlNext.settingErr = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctlReg <= '{mode: MODE_RST, chan: CHAN_RST, trig: TRIG_RST,
                     resWord: RESULT_WORD_RST, resByte: RESULT_BYTE_RST,
                     rdData: 16'h0000, state: ST_IDLE, slot: 2'h0,
                     rangeSync1: 1'b0, rangeSync2: 1'b0, settingErr: 1'b0,
                     convEnd: 1'b0, muxCode: 4'h0, muxAmp: 1'b0};
      end else begin
         ctlReg <= ctlNext;
      end
   end

   // ----------------------------------------------------------------
   // Divider and approximation sequencer
   // ----------------------------------------------------------------
   // divider code from mode register
   adtc_clk_div uDiv (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .restart(divRestart),
      .divCode(ctlReg.mode[MODE_DIV_LSB +: 3]),
      .tick(divTick)
   );

   adtc_sar uSar (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(sarStart),
      .abort(sarAbort),
      .tick(divTick),
      .compareHigh(compareHigh),
      .sampling(sarSampling),
      .busy(sarBusy),
      .done(sarDone),
      .trial(sarTrial),
      .result(sarResult)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign regRdData = ctlReg.rdData;
   assign comparatorEnable = ctlReg.mode[MODE_CMP_EN_BIT];
   assign sampleHold = sarSampling;
   assign trialValue = sarTrial;
   assign channelCode = ctlReg.muxCode;
   assign amplifierSelect = ctlReg.muxAmp;
   assign speedMode = ctlReg.mode[MODE_SPEED_LSB +: 2];
   assign conversionEnd = ctlReg.convEnd;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence scanStep;
      sarDone && scanMode && ctlReg.state == ST_CONVERT &&
      ctlReg.slot != LAST_SLOT && !wrChan && runBit;
   endsequence
   sequence lastStep;
      sarDone && ctlReg.state == ST_CONVERT && !wrChan && runBit &&
      (!scanMode || ctlReg.slot == LAST_SLOT);
   endsequence

   chk_trig_reserved: assert property (ctlReg.trig[6:1] == 6'h00)
      else $error("trigger reserved bits not zero");
   chk_trig_readback: assert property (regRead && regAddr == OFS_TRIGGER |=>
      regRdData == {8'h00, $past(ctlReg.trig)})
      else $error("trigger register read mismatch");
   chk_result_pad: assert property (ctlReg.resWord[5:0] == 6'h00)
      else $error("result word low bits not zero");
   chk_result_pair: assert property (ctlReg.resByte == ctlReg.resWord[15:8])
      else $error("result byte differs from word high byte");
   chk_result_load: assert property (sarDone && ctlReg.state == ST_CONVERT |=>
      ctlReg.resWord[15:6] == $past(sarResult))
      else $error("result not loaded at completion");
   chk_sw_start: assert property (ctlReg.state == ST_IDLE && runBit && !hwTrigMode &&
      !prohibited |=> ctlReg.state == ST_CONVERT ##0 sarBusy)
      else $error("software start did not begin conversion");
   chk_hw_wait: assert property (ctlReg.state == ST_WAIT_TRIG && !selTrig && runBit &&
      !wrChan |=> ctlReg.state == ST_WAIT_TRIG)
      else $error("left trigger wait without selected trigger");
   chk_run_stop: assert property (!runBit |=> ctlReg.state == ST_IDLE && !sarBusy)
      else $error("conversion continued after run cleared");
   chk_chan_restart: assert property (wrChan && ctlReg.state == ST_CONVERT |=>
      !sarBusy && ctlReg.slot == 2'h0)
      else $error("channel write did not reinitialise conversion");
   chk_scan_step: assert property (scanStep |=>
      ctlReg.slot == $past(ctlReg.slot) + 2'h1 && !conversionEnd)
      else $error("scan slot did not advance");
   chk_end_pulse: assert property (lastStep |=> conversionEnd ##1 !conversionEnd)
      else $error("end pulse missing or too long");
   chk_speed_block: assert property (ctlReg.state == ST_IDLE && prohibited |=>
      ctlReg.state == ST_IDLE)
      else $error("conversion started in barred setting");

endmodule : adtc_ctrl

// file: adtc_analog_model.sv
// Analog front end model: fixed input levels against the trial value.
// Assumes the controller samples compareHigh on its own clock.
module adtc_analog_model (
   // Clock
   input wire logic ref_clk,
   // From controller
   input wire logic comparatorEnable,
   input wire logic amplifierSelect,
   input wire logic [3:0] channelCode,
   input wire logic [9:0] trialValue,
   // To controller
   output logic compareHigh
);
   timeunit 1ns;
   timeprecision 1ps;
   logic junk = 1'b0;
   logic [9:0] level;
   assign level = amplifierSelect ? 10'h2AB : {channelCode, 6'h25};
   // Comparator off gives no real answer, so it toggles
   always @(posedge ref_clk) junk <= ~junk;
   assign compareHigh = comparatorEnable ? (level >= trialValue) : junk;
endmodule : adtc_analog_model

// file: test_adtc_ctrl.sv
// Self-checking bench for the A/D control block.
// Assumes the analog model answers within the same clock.
module test_adtc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import adtc_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [19:0] regAddr = 20'h00000;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdData;
   logic timerTrig0 = 1'b0;
   logic timerTrig1 = 1'b0;
   logic refRangeLow = 1'b0;
   logic compareHigh, comparatorEnable, sampleHold, amplifierSelect, conversionEnd;
   logic [9:0] trialValue;
   logic [3:0] channelCode;
   logic [1:0] speedMode;
   logic rdPend = 1'b0;
   logic holdLast = 1'b0;
   logic [15:0] expQ[$];
   logic [15:0] maskQ[$];
   logic [4:0] slotQ[$];
   logic [31:0] lfsr = 32'h16A73;
   logic [15:0] mk;
   logic [7:0] c;
   logic [4:0] e;
   logic [7:0] scanCode [3] = '{8'h02, 8'h47, 8'h07};
   int rat [8] = '{20, 10, 8, 6, 4, 3, 2, 1};
   int error_cnt = 0;
   int samples_checked = 0;
   int n;

   adtc_ctrl adtc_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .timerTrig0(timerTrig0), .timerTrig1(timerTrig1), .refRangeLow(refRangeLow),
      .compareHigh(compareHigh), .comparatorEnable(comparatorEnable),
      .sampleHold(sampleHold), .trialValue(trialValue), .channelCode(channelCode),
      .amplifierSelect(amplifierSelect), .speedMode(speedMode),
      .conversionEnd(conversionEnd));
   adtc_analog_model adtc_analog_model_inst (.ref_clk(ref_clk),
      .comparatorEnable(comparatorEnable), .amplifierSelect(amplifierSelect),
      .channelCode(channelCode), .trialValue(trialValue), .compareHigh(compareHigh));

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= {8'h00, d};
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [15:0] x, input logic [15:0] m);
      @(posedge ref_clk);
      expQ.push_back(x);
      maskQ.push_back(m);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
   endtask : rd

   task automatic waitEnd(input int lim);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (conversionEnd !== 1'b1 && n < lim);
   endtask : waitEnd

   task automatic trig(input logic sel);
      @(posedge ref_clk);
      if (sel) timerTrig1 <= 1'b1;
      else timerTrig0 <= 1'b1;
      @(posedge ref_clk);
      timerTrig0 <= 1'b0;
      timerTrig1 <= 1'b0;
   endtask : trig

   function automatic logic [31:0] lfsrStep(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsrStep

   function automatic logic [15:0] word(input logic [3:0] ch, input logic amp);
      return amp ? {10'h2AB, 6'h00} : {ch, 6'h25, 6'h00};
   endfunction : word

   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk) rdPend <= regRead;
   always @(negedge ref_clk) begin
      holdLast <= sampleHold;
      if (!sampleHold && holdLast) slotQ.push_back({amplifierSelect, channelCode});
      if (rdPend) begin
         mk = maskQ.pop_front();
         chk(regRdData & mk, expQ.pop_front() & mk);
      end
   end

   initial begin
      #160000;
      error_cnt++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(OFS_RESULT_WORD, 16'h0000, 16'hFFFF);
      rd(OFS_RESULT_BYTE, 16'h0000, 16'hFFFF);
      rd(OFS_CHANNEL, 16'h0000, 16'hFFFF);
      rd(OFS_TRIGGER, 16'h0000, 16'hFFFF);
      rd(20'h00000, 16'h0000, 16'hFFFF);
      wr(OFS_TRIGGER, 8'hFF);
      rd(OFS_TRIGGER, 16'h0081, 16'hFFFF);
      wr(OFS_RESULT_WORD, 8'h55);
      rd(OFS_RESULT_WORD, 16'h0000, 16'hFFFF);
      wr(OFS_TRIGGER, 8'h00);
      wr(OFS_MODE, 8'h39);
      // select mode, pins all analog, last pass on the amplifier
      for (int i = 0; i < 5; i++) begin
         lfsr = lfsrStep(lfsr);
         c = (i == 4) ? {4'h4, lfsr[3:0]} : 8'(lfsr[7:0] % 10);
         wr(OFS_CHANNEL, c);
         slotQ.delete();
         wr(OFS_MODE, 8'hB9);
         waitEnd(60);
         chk(16'(n < 60), 16'h0001);
         rd(OFS_RESULT_WORD, word(c[3:0], c[6]), 16'hFFFF);
         rd(OFS_RESULT_BYTE, 16'(word(c[3:0], c[6]) >> 8), 16'hFFFF);
         wr(OFS_MODE, 8'h39);
         chk({11'h000, slotQ[0]}, c[6] ? 16'h0010 : {12'h000, c[3:0]});
      end
      for (int s = 0; s < 3; s++) begin
         wr(OFS_CHANNEL, scanCode[s]);
         slotQ.delete();
         wr(OFS_MODE, 8'hF9);
         waitEnd(200);
         for (int k = 0; k < 4; k++) begin
            c = scanCode[s];
            if (c[6]) e = (k == 0) ? 5'h10 : {1'b0, c[3:0] + 4'(k - 1)};
            else e = (c[3:0] <= 4'h6) ? {1'b0, c[3:0] + 4'(k)} : 5'(k);
            chk({11'h000, slotQ[k]} & (e[4] ? 16'h0010 : 16'h001F), {11'h000, e});
         end
         rd(OFS_RESULT_WORD, word(e[3:0], 1'b0), 16'hFFFF);
         wr(OFS_MODE, 8'h79);
      end
      // divider ratio, run cleared before each change
      wr(OFS_CHANNEL, 8'h00);
      for (int d = 0; d < 8; d++) begin
         wr(OFS_MODE, 8'h01 | 8'(d << 3));
         wr(OFS_MODE, 8'h81 | 8'(d << 3));
         waitEnd(300);
         waitEnd(300);
         chk(16'(n >= 12 * rat[d] && n <= 13 * rat[d] + 4), 16'h0001);
         wr(OFS_MODE, 8'h01 | 8'(d << 3));
      end
      wr(OFS_MODE, 8'h01);
      wr(OFS_MODE, 8'h81);
      repeat (100) @(posedge ref_clk);
      wr(OFS_CHANNEL, 8'h01);
      waitEnd(400);
      chk(16'(n >= 240 && n < 400), 16'h0001);
      rd(OFS_RESULT_WORD, word(4'h1, 1'b0), 16'hFFFF);
      wr(OFS_MODE, 8'h01);
      // speed modes at the low reference range
      refRangeLow <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int sp = 0; sp < 4; sp++) begin
         wr(OFS_MODE, 8'h39 | 8'(sp << 1));
         wr(OFS_MODE, 8'hB9 | 8'(sp << 1));
         waitEnd(40);
         chk(16'(n < 40), 16'((sp == 0) || (sp == 3)));
         chk({13'h0000, comparatorEnable, speedMode}, 16'h0004 | 16'(sp));
         rd(OFS_STATUS, (sp == 1 || sp == 2) ? 16'h0008 : 16'h0000, 16'h0008);
         wr(OFS_MODE, 8'h39 | 8'(sp << 1));
      end
      wr(OFS_MODE, 8'h39);
      refRangeLow <= 1'b0;
      // timer trigger, set only while stopped
      for (int t = 0; t < 2; t++) begin
         wr(OFS_TRIGGER, 8'h80 | 8'(t));
         wr(OFS_MODE, 8'hB9);
         trig(!t[0]);
         waitEnd(40);
         chk(16'(n < 40), 16'h0000);
         trig(t[0]);
         waitEnd(40);
         chk(16'(n < 40), 16'h0001);
         waitEnd(40);
         chk(16'(n < 40), 16'h0000);
         wr(OFS_MODE, 8'h39);
         wr(OFS_TRIGGER, 8'h00);
      end
      repeat (4) @(posedge ref_clk);
      print_verdict();
   end
endmodule : test_adtc_ctrl
